// ===== irke_encoder.v
`timescale 1ns/1ps
`include "irke_defines.vh"
module irke_encoder #(
  parameter       WAKE_ENABLE = 1,          // Mask option: key wake-up
  parameter [7:0] CUSTOM_LOW  = 8'h00,      // Custom code low byte
  parameter [7:0] CUSTOM_HIGH = 8'hff       // Custom code high byte
) (
  input  wire       core_clk,
  input  wire       rstn,
  input  wire [3:0] key_column_inputs_low,  // Columns 0..3, low when pressed
  input  wire [3:0] key_column_inputs_high, // Columns 4..7, low when pressed
  input  wire       plain_format,           // High selects unmodulated output
  output reg  [3:0] scan_row_outputs,       // Row strobes, active low
  output reg  [1:0] custom_code_lines,      // Custom code lines
  output reg        ir_transmit_output,     // Transmit line
  output reg        tx_busy,                // Transmission in progress
  output reg        osc_run                 // Oscillator running
);

  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  localparam [4:0] ST_STBY = 5'h01;         // Stand-by
  localparam [4:0] ST_SCAN = 5'h02;         // Row scan
  localparam [4:0] ST_ON   = 5'h04;         // Pulse on
  localparam [4:0] ST_OFF  = 5'h08;         // Pulse off
  localparam [4:0] ST_GAP  = 5'h10;         // Frame interval

  reg  [4:0]  state_reg;                    // Current state
  reg  [1:0]  row_reg;                      // Active row index
  reg  [3:0]  dwell_reg;                    // Row dwell counter
  reg  [5:0]  key1_reg;                     // First key code seen
  reg  [5:0]  key2_reg;                     // Second key code seen
  reg  [31:0] shift_reg;                    // Frame bits
  reg  [5:0]  bit_reg;                      // Bit index, 32 = lead
  reg  [15:0] time_reg;                     // Phase timer
  reg  [3:0]  car_reg;                      // Carrier divider
  reg         pulse_reg;                    // Raw pulse level

  wire [7:0]  cols  = {key_column_inputs_high, key_column_inputs_low};
  wire        any_low = ~&cols;             // Any key input low
  reg  [5:0]  col_code;                     // Lowest pressed column code
  reg  [7:0]  key_code;                     // Mapped key code
  reg  [7:0]  mask;
  integer     i;                            // First-key column loop index
  integer     j;                            // Second-key column loop index

  // ---------------------------------------------------------------
  // Column encode for current row
  // ---------------------------------------------------------------
  // Lowest-numbered pressed column, code = 8*row + col + 1
  always @* begin
    col_code = 6'd0;
    for (i = 7; i >= 0; i = i - 1) begin
      if (!cols[i]) begin
        col_code = {1'b0, row_reg, 3'd0} + i[5:0] + 6'd1;
      end
    end
  end

  // Second pressed key in the same row, masking the first
  reg [5:0] col_code2;
  always @* begin
    col_code2 = 6'd0;
    mask = cols;
    for (j = 0; j < 8; j = j + 1) begin
      if (!mask[j] && col_code2 == 6'd0 && ({1'b0, row_reg, 3'd0} + j[5:0] + 6'd1) != col_code) begin
        col_code2 = {1'b0, row_reg, 3'd0} + j[5:0] + 6'd1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Combination mapping
  // ---------------------------------------------------------------
  always @* begin
    key_code = {2'b00, key1_reg};
    if (key1_reg == `IRKE_COMBO_BASE) begin
      case (key2_reg)
        `IRKE_COMBO_A_KEY: key_code = `IRKE_COMBO_A_CODE;
        `IRKE_COMBO_B_KEY: key_code = `IRKE_COMBO_B_CODE;
        `IRKE_COMBO_C_KEY: key_code = `IRKE_COMBO_C_CODE;
        default:           key_code = {2'b00, key1_reg};
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Control state machine
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!rstn) begin
      state_reg <= ST_STBY;
      row_reg   <= 2'd0;
      dwell_reg <= 4'd0;
      key1_reg  <= 6'd0;
      key2_reg  <= 6'd0;
      shift_reg <= 32'h0000_0000;
      bit_reg   <= 6'd0;
      time_reg  <= 16'h0000;
      pulse_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_STBY: begin
          pulse_reg <= 1'b0;
          if (WAKE_ENABLE != 0 && any_low) begin
            state_reg <= ST_SCAN;
            row_reg   <= 2'd0;
            dwell_reg <= 4'd0;
            key1_reg  <= 6'd0;
            key2_reg  <= 6'd0;
          end
        end
        ST_SCAN: begin
          // Sample columns per row after dwell
          if (dwell_reg == `IRKE_ROW_DWELL) begin
            dwell_reg <= 4'd0;
            if (col_code != 6'd0) begin
              if (key1_reg == 6'd0) begin
                key1_reg <= col_code;
                if (col_code2 != 6'd0) key2_reg <= col_code2;
              end else if (key2_reg == 6'd0) begin
                key2_reg <= col_code;
              end
            end
            if (row_reg == 2'd3) begin
              row_reg <= 2'd0;
              if (key1_reg == 6'd0 && col_code == 6'd0) begin
                state_reg <= ST_STBY;
              end else begin
                state_reg <= ST_ON;
                bit_reg   <= `IRKE_FRAME_BITS;
                time_reg  <= `IRKE_LEAD_ON;
                pulse_reg <= 1'b1;
              end
            end else begin
              row_reg <= row_reg + 2'd1;
            end
          end else begin
            dwell_reg <= dwell_reg + 4'd1;
          end
        end
        ST_ON: begin
          // Latch frame during lead, once a last-row key has settled
          if (bit_reg == `IRKE_FRAME_BITS) begin
            shift_reg <= {~key_code, key_code, CUSTOM_HIGH, CUSTOM_LOW};
          end
          if (time_reg == 16'h0001) begin
            pulse_reg <= 1'b0;
            state_reg <= ST_OFF;
            if (bit_reg == `IRKE_FRAME_BITS) time_reg <= `IRKE_LEAD_OFF;
            else if (shift_reg[0])          time_reg <= `IRKE_ONE_OFF;
            else                            time_reg <= `IRKE_ZERO_OFF;
          end else begin
            time_reg <= time_reg - 16'h0001;
          end
        end
        ST_OFF: begin
          if (time_reg == 16'h0001) begin
            if (bit_reg != `IRKE_FRAME_BITS) shift_reg <= {1'b0, shift_reg[31:1]};
            if (bit_reg == `IRKE_STOP_MARK) begin
              // Stop pulse done, wait frame interval
              state_reg <= ST_GAP;
              time_reg  <= `IRKE_FRAME_GAP;
            end else begin
              // Counting down past bit 0 lands on the stop pulse index
              bit_reg   <= (bit_reg == `IRKE_FRAME_BITS) ? 6'd31 : bit_reg - 6'd1;
              state_reg <= ST_ON;
              time_reg  <= `IRKE_BIT_ON;
              pulse_reg <= 1'b1;
            end
          end else begin
            time_reg <= time_reg - 16'h0001;
          end
        end
        ST_GAP: begin
          if (time_reg == 16'h0001) begin
            state_reg <= ST_SCAN;
            row_reg   <= 2'd0;
            dwell_reg <= 4'd0;
            key1_reg  <= 6'd0;
            key2_reg  <= 6'd0;
          end else begin
            time_reg <= time_reg - 16'h0001;
          end
        end
        default: state_reg <= ST_STBY;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Carrier divider
  // ---------------------------------------------------------------
  // Divide by twelve, one-third high
  always @(posedge core_clk) begin
    if (!rstn || state_reg == ST_STBY) begin
      car_reg <= 4'd0;
    end else if (car_reg == `IRKE_CAR_DIV - 4'd1) begin
      car_reg <= 4'd0;
    end else begin
      car_reg <= car_reg + 4'd1;
    end
  end

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!rstn) begin
      scan_row_outputs   <= 4'h0;
      custom_code_lines  <= 2'h3;
      ir_transmit_output <= 1'b0;
      tx_busy            <= 1'b0;
      osc_run            <= 1'b0;
    end else begin
      // Stand-by pin levels and stopped clock
      osc_run           <= (state_reg != ST_STBY);
      custom_code_lines <= 2'h3;
      if (state_reg == ST_SCAN) begin
        // One row low at a time
        scan_row_outputs <= ~(4'h1 << row_reg);
      end else begin
        scan_row_outputs <= 4'h0;
      end
      ir_transmit_output <= pulse_reg & (plain_format | (car_reg < `IRKE_CAR_HIGH));
      tx_busy <= (state_reg == ST_ON) || (state_reg == ST_OFF);
    end
  end

endmodule

// ===== irke_defines.vh
`ifndef IRKE_DEFINES_VH
`define IRKE_DEFINES_VH
// Oscillator rate in kHz and carrier divide ratio
`define IRKE_OSC_KHZ        455
`define IRKE_CAR_DIV        4'd12
// Carrier high phase, one third of the period
`define IRKE_CAR_HIGH       4'd4
// Combination codes
`define IRKE_COMBO_BASE     6'd21
`define IRKE_COMBO_A_KEY    6'd22
`define IRKE_COMBO_B_KEY    6'd23
`define IRKE_COMBO_C_KEY    6'd24
`define IRKE_COMBO_A_CODE   8'h35
`define IRKE_COMBO_B_CODE   8'h36
`define IRKE_COMBO_C_CODE   8'h37
// Frame layout: lead, then 16 custom bits, then 8 code and 8 inverted code bits
`define IRKE_FRAME_BITS     6'd32
// Bit index of the closing stop pulse, reached by counting down past bit 0
`define IRKE_STOP_MARK      6'h3f
// Timing in carrier-free ticks of the core clock (shortened defaults)
`define IRKE_LEAD_ON        16'h0010
`define IRKE_LEAD_OFF       16'h0008
`define IRKE_BIT_ON         16'h0002
`define IRKE_ZERO_OFF       16'h0002
`define IRKE_ONE_OFF        16'h0006
`define IRKE_FRAME_GAP      16'h0040
// Scan dwell per row in core clocks
`define IRKE_ROW_DWELL      4'd3
`endif

// ===== irke_key_matrix.sv
`timescale 1ns/1ps
// ----------------------------------------
// Key matrix model with column pull-ups
// ----------------------------------------
module irke_key_matrix (
  input  wire  [3:0]  scan_row_outputs,       // Row strobes, low selects
  input  wire  [31:0] key_pressed,            // Bit n is key code n+1
  output logic [3:0]  key_column_inputs_low,  // Columns 0..3
  output logic [3:0]  key_column_inputs_high  // Columns 4..7
);
  logic [7:0] col_level;  // Pulled-up column levels
  always_comb begin
    col_level = 8'hff;
    for (int r = 0; r < 4; r++)
      for (int c = 0; c < 8; c++)
        if (key_pressed[r*8+c] && !scan_row_outputs[r]) col_level[c] = 1'b0;
    key_column_inputs_low  = col_level[3:0];
    key_column_inputs_high = col_level[7:4];
  end
endmodule

// ===== irke_checker.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port-level checker
// ----------------------------------------
module irke_checker (
  input wire       core_clk,
  input wire       rstn,
  input wire [3:0] key_column_inputs_low,
  input wire [3:0] key_column_inputs_high,
  input wire       plain_format,
  input wire [3:0] scan_row_outputs,
  input wire [1:0] custom_code_lines,
  input wire       ir_transmit_output,
  input wire       tx_busy,
  input wire       osc_run
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Quiet gap after a frame
  sequence s_gap; !tx_busy[*8]; endsequence
  // Four carrier-high cycles
  sequence s_hi4; (!plain_format && ir_transmit_output)[*4]; endsequence
  a_standby_rows: assert property (!osc_run |-> scan_row_outputs == 4'h0) else $error("rows not low");
  a_custom_high: assert property (custom_code_lines == 2'h3) else $error("custom lines low");
  a_wake_up: assert property (!osc_run && (key_column_inputs_low != 4'hf || key_column_inputs_high != 4'hf)
    |-> ##[1:3] osc_run) else $error("no wake");
  a_one_row: assert property (scan_row_outputs != 4'h0 |-> $onehot(~scan_row_outputs)) else $error("rows");
  a_busy_line: assert property (!tx_busy |-> !ir_transmit_output) else $error("pulse while idle");
  a_plain_pulse: assert property (plain_format && $rose(ir_transmit_output) |=> ir_transmit_output)
    else $error("short pulse");
  a_carrier_duty: assert property (s_hi4 |=> !ir_transmit_output) else $error("carrier high too long");
  a_frame_gap: assert property ($fell(tx_busy) |=> s_gap) else $error("gap short");
endmodule
bind irke_encoder irke_checker i_irke_checker (.core_clk(core_clk), .rstn(rstn),
  .key_column_inputs_low(key_column_inputs_low), .key_column_inputs_high(key_column_inputs_high),
  .plain_format(plain_format), .scan_row_outputs(scan_row_outputs), .custom_code_lines(custom_code_lines),
  .ir_transmit_output(ir_transmit_output), .tx_busy(tx_busy), .osc_run(osc_run));

// ===== irke_encoder_tb.sv
`timescale 1ns/1ps
module irke_encoder_tb;
  logic        core_clk, rstn, plain_format;
  logic [31:0] key_pressed;  // Held keys
  logic [31:0] frame;        // Decoded frame
  wire  [3:0]  col_lo, col_hi, rows;
  wire  [1:0]  cust;
  wire         tx, busy, osc;
  int          n_mismatch, check_count;
  // ----------------------------------------
  // Design and key matrix
  // ----------------------------------------
  irke_encoder i_irke_encoder (.core_clk(core_clk), .rstn(rstn), .key_column_inputs_low(col_lo),
    .key_column_inputs_high(col_hi), .plain_format(plain_format), .scan_row_outputs(rows),
    .custom_code_lines(cust), .ir_transmit_output(tx), .tx_busy(busy), .osc_run(osc));
  irke_key_matrix i_irke_key_matrix (.scan_row_outputs(rows), .key_pressed(key_pressed),
    .key_column_inputs_low(col_lo), .key_column_inputs_high(col_hi));
  // Clock generation
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task give_verdict;
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Bounded wait for a level on the line
  task wait_line(input logic v, input logic sig_busy);
    int n;
    n = 0;
    while ((sig_busy ? busy : tx) !== v && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 3000) check(0, 1, "wait ran out");
  endtask
  // Decode one plain-format frame, low bit first
  task get_frame;
    int n;
    wait_line(0, 1);
    wait_line(1, 1);
    wait_line(1, 0);
    wait_line(0, 0);
    for (int i = 0; i < 32; i++) begin
      wait_line(1, 0);
      wait_line(0, 0);
      n = 0;
      while (tx !== 1'b1 && n < 20) begin
        @(negedge core_clk);
        n++;
      end
      frame[i] = (n > 3);
    end
  endtask
  // Release keys and expect stand-by
  task release_keys;
    key_pressed = 32'h0;
    wait_line(0, 1);
    repeat (100) @(negedge core_clk);
    check(osc, 0, "no stand-by");
    check(rows, 4'h0, "rows in stand-by");
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Press keys a and b, expect code, twice
  task t_keys(input int a, input int b, input logic [7:0] code);
    key_pressed = (32'h1 << (a - 1)) | (b > 0 ? 32'h1 << (b - 1) : 32'h0);
    get_frame;
    check(frame, {~code, code, 8'hff, 8'h00}, "frame");
    get_frame;
    check(frame, {~code, code, 8'hff, 8'h00}, "repeat");
    release_keys;
  endtask
  // Modulated frame shows busy and carrier
  task t_modulated;
    int run, run_max;
    plain_format = 1'b0;
    key_pressed  = 32'h10;
    wait_line(1, 1);
    check(busy, 1, "no busy");
    // Lead pulse spans 16 cycles: longest high run must be one carrier high
    run     = 0;
    run_max = 0;
    repeat (16) begin
      run = (tx === 1'b1) ? run + 1 : 0;
      if (run > run_max) run_max = run;
      @(negedge core_clk);
    end
    check(run_max, 4, "carrier high run");
    wait_line(1, 0);
    check(tx, 1, "no carrier");
    release_keys;
    plain_format = 1'b1;
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    n_mismatch   = 0;
    check_count  = 0;
    rstn         = 1'b0;
    plain_format = 1'b1;
    key_pressed  = 32'h0;
    repeat (2) @(negedge core_clk);
    check({cust, rows, tx, busy, osc}, 9'h180, "reset values");
    rstn = 1'b1;
    t_keys(1, 0, 8'h01);
    t_keys(32, 0, 8'h20);
    t_keys(13, 0, 8'h0d);
    // Each combination of the base key
    for (int k = 0; k < 3; k++) t_keys(21, 22 + k, 8'h35 + k);
    t_modulated;
    give_verdict;
  end
  initial begin
    #800000;
    n_mismatch++;
    give_verdict;
  end
endmodule
